/* File: verilog/rom_code_crc8_checker.sv */
// 8-bit check generator and checker for 64-bit identification codes
// assumes bits arrive lsb first from the family byte; one clock, sync reset
`timescale 1ns/1ps
// Behaviour
// - eight-stage register, polynomial x8+x5+x4+1
// - input xor last stage feeds first stage
// - feedback xors after stages four, five
// - clear to zero before each calculation
// - bits enter lsb first, family byte first
// - family low byte, serial, check high byte
// - check byte is value after 56 bits
// - register holds remainder after last bit
// - feeding register value back gives zero
// - byte update via table equals eight steps
// - complement byte input leaves 35 hex
module rom_code_crc8_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // requests
  input crc8_pkg::crc_in_t req,
  // results
  output crc8_pkg::crc_out_t status,
  output logic busy
);
  // ************************************
  // serial update function
  // ************************************
  function automatic logic [7:0] shift1(input logic [7:0] r, input logic d);
    logic fb;
    fb = d ^ r[0];
    // right-shifting view: xor 18 hex before shift equals taps after stages 4 and 5
    return fb ? ({1'b1, r[7:1]} ^ {1'b0, crc8_pkg::TAP_MASK[7:1]}) : {1'b0, r[7:1]};
  endfunction : shift1

  // ************************************
  // helper functions
  // ************************************
  // remainder test, used by the verdict and by the status flag
  function automatic logic zeroValue(input logic [7:0] r);
    return (r == 8'h00);
  endfunction : zeroValue

  // true only on the step that lands exactly on the last code bit
  function automatic logic endOfCode(input logic [6:0] c, input logic [6:0] s);
    logic [6:0] sum;
    sum = c + s;
    return (s != 7'h00) && (sum == 7'(crc8_pkg::CODE_BITS));
  endfunction : endOfCode

  // ************************************
  // state
  // ************************************
  crc8_pkg::chk_state_t state;
  crc8_pkg::chk_state_t next_state;
  logic [7:0] crc;
  logic [7:0] next_crc;
  logic [6:0] count;
  logic [6:0] next_count;
  logic done;
  logic next_done;
  logic error;
  logic next_error;
  logic good;
  logic next_good;
  logic pendByte;
  logic next_pendByte;
  logic [7:0] tableEntry;

  // ************************************
  // byte lookup
  // ************************************
  // byte update through a registered table, so a byte takes two cycles
  crc8_table_rom #(
    .DEPTH(crc8_pkg::TABLE_DEPTH)
  ) u_table (
    .clock(clock),
    .index(crc ^ req.byteIn),
    .entry(tableEntry)
  );

  assign busy = pendByte;

  // ************************************
  // request decode
  // ************************************
  logic running;
  logic takeClear;
  logic takeByte;
  logic takeBit;
  logic finishByte;
  logic [6:0] stepCount;
  logic [7:0] stepCrc;
  logic reachEnd;

  // clear wins over everything; a pending byte blocks new bit or byte requests
  always_comb begin
    running = (state == crc8_pkg::ST_RUN);
    takeClear = req.clear;
    finishByte = running && !req.clear && pendByte;
    takeByte = running && !req.clear && !pendByte && req.byteValid;
    takeBit = running && !req.clear && !pendByte && !req.byteValid && req.bitValid;
    stepCount = 7'h00;
    stepCrc = crc;
    if (finishByte) begin
      // table result covers complement and self-feed identities too
      stepCrc = tableEntry;
      stepCount = 7'(crc8_pkg::CRC_W);
    end else if (takeBit) begin
      stepCrc = shift1(crc, req.bitIn);
      stepCount = 7'h01;
    end
    // overshooting 64 by a late byte ends only once the 7-bit count wraps round to 64 again; reader must clear again
    reachEnd = endOfCode(count, stepCount);
  end

  // ************************************
  // control group
  // ************************************
  always_comb begin
    next_state = state;
    next_count = count;
    next_done = 1'b0;
    next_pendByte = takeByte;
    case (state)
      crc8_pkg::ST_IDLE, crc8_pkg::ST_DONE: begin
        if (takeClear) begin
          next_count = crc8_pkg::COUNT_RESET;
          next_state = crc8_pkg::ST_RUN;
        end
      end
      crc8_pkg::ST_RUN: begin
        if (takeClear) begin
          next_count = crc8_pkg::COUNT_RESET;
        end else begin
          next_count = count + stepCount;
          if (reachEnd) begin
            next_done = 1'b1;
            next_state = crc8_pkg::ST_DONE;
          end
        end
      end
      default: begin
        next_state = crc8_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= crc8_pkg::ST_IDLE;
      count <= crc8_pkg::COUNT_RESET;
      done <= 1'b0;
      pendByte <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      done <= next_done;
      pendByte <= next_pendByte;
    end
  end

  // ************************************
  // register group
  // ************************************
  always_comb begin
    if (takeClear) begin
      next_crc = crc8_pkg::CRC_RESET;
    end else begin
      next_crc = stepCrc;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      crc <= crc8_pkg::CRC_RESET;
    end else begin
      crc <= next_crc;
    end
  end

  // ************************************
  // verdict group
  // ************************************
  // verdict levels stand until the next clear so a slow reader can poll them
  always_comb begin
    next_error = error;
    next_good = good;
    if (takeClear) begin
      next_error = 1'b0;
      next_good = 1'b0;
    end else if (reachEnd) begin
      // 64 bits in: remainder zero means good read
      next_good = zeroValue(stepCrc);
      next_error = !zeroValue(stepCrc);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      error <= 1'b0;
      good <= 1'b0;
    end else begin
      error <= next_error;
      good <= next_good;
    end
  end

  // ************************************
  // status
  // ************************************
  // after 56 bits crc equals the check byte for byte 7; readers compare here
  always_comb begin
    status.crc = crc;
    status.isZero = zeroValue(crc);
    status.bitCount = count;
    status.done = done;
    status.error = error;
    status.good = good;
  end
endmodule : rom_code_crc8_checker

/* File: verilog/crc8_pkg.sv */
// shared constants and carrier types for the identification-code check block
// assumes a single clock domain and synchronous reset
package crc8_pkg;
  // ************************************
  // polynomial and sizes
  // ************************************
  localparam int CRC_W = 8;
  localparam logic [7:0] REFLECTED_TAPS = 8'h8c;
  localparam logic [7:0] TAP_MASK = 8'h18;
  localparam logic [7:0] CRC_RESET = 8'h00;
  localparam logic [7:0] COMPLEMENT_RESULT = 8'h35;
  localparam int CODE_BITS = 64;
  localparam int DATA_BITS = 56;
  localparam int CODE_BYTES = 8;
  localparam int FAMILY_BYTE = 0;
  localparam int SERIAL_BYTES = 6;
  localparam int CHECK_BYTE = 7;
  localparam int TABLE_DEPTH = 256;
  localparam logic [6:0] COUNT_RESET = 7'h00;
  // example family value, arbitrary
  localparam logic [7:0] FAMILY_DEFAULT = 8'h5a;

  // ************************************
  // carriers
  // ************************************
  typedef struct packed {
    logic clear;
    logic bitValid;
    logic bitIn;
    logic byteValid;
    logic [7:0] byteIn;
  } crc_in_t;

  typedef struct packed {
    logic [7:0] crc;
    logic isZero;
    logic [6:0] bitCount;
    logic done;
    logic error;
    logic good;
  } crc_out_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } chk_state_t;
endpackage : crc8_pkg

/* File: verilog/crc8_table_rom.sv */
// 256-entry lookup of the byte-wide update, registered read data
// assumes the caller presents index one cycle before it needs the entry
`timescale 1ns/1ps
module crc8_table_rom #(
  parameter int DEPTH = crc8_pkg::TABLE_DEPTH
) (
  // clock
  input wire logic clock,
  // lookup
  input wire logic [7:0] index,
  output logic [7:0] entry
);
  logic [7:0] table_mem [DEPTH];
  logic [7:0] next_entry;

  // table built as eight serial steps starting from the index value, with zero data in
  function automatic logic [7:0] step8(input logic [7:0] value);
    logic [7:0] r;
    r = value;
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ crc8_pkg::REFLECTED_TAPS) : (r >> 1);
    end
    return r;
  endfunction : step8

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      table_mem[i] = step8(8'(i));
    end
  end

  always_comb begin
    next_entry = table_mem[index];
  end

  always_ff @(posedge clock) begin
    entry <= next_entry;
  end
endmodule : crc8_table_rom

/* File: test/crc8_assertions.sv */
// port checks for the code check block
// assumes one clock, sync reset
`timescale 1ns/1ps
module crc8_assertions (
  input wire logic clock,
  input wire logic rst,
  input crc8_pkg::crc_in_t req,
  input crc8_pkg::crc_out_t status,
  input wire logic busy
);
  function automatic logic [7:0] st(logic [7:0] c, logic b);
    return (c >> 1) ^ ({8{c[0] ^ b}} & 8'h8c);
  endfunction : st
  function automatic logic [7:0] sb(logic [7:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++) c = st(c, d[i]);
    return c;
  endfunction : sb
  logic run;
  logic act;
  always_ff @(posedge clock) run <= !rst && (req.clear || (run && !status.done));
  // bit and byte requests are only taken while running and not busy; clear is taken in any state
  assign act = run && !status.done && !req.clear && !busy;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_clear_zero: assert property (req.clear |=> status.crc == 8'h00 && status.bitCount == 7'h00)
    else $error("clear");
  a_bit_shift: assert property (act && req.bitValid && !req.byteValid |=>
    status.crc == st($past(status.crc), $past(req.bitIn))) else $error("shift");
  a_bit_count: assert property (act && req.bitValid && !req.byteValid |=>
    status.bitCount == $past(status.bitCount) + 7'h01) else $error("count");
  a_byte_step: assert property (act && req.byteValid |=> busy ##1
    (!busy && status.crc == sb($past(status.crc, 2), $past(req.byteIn, 2)))) else $error("byte");
  a_zero_flag: assert property (status.isZero == (status.crc == 8'h00)) else $error("zero");
  a_done_count: assert property (status.done |-> status.bitCount == 7'h40) else $error("done");
  a_done_verdict: assert property (status.done |-> status.good == status.isZero
    && status.error == !status.isZero) else $error("verdict");
  a_idle_hold: assert property ((!run || status.done) && !req.clear |=> $stable(status.crc))
    else $error("hold");
  cover property (status.done && status.good);
  cover property (status.done && status.error);
  cover property (act && req.byteValid);
endmodule : crc8_assertions

/* File: test/code_reader_model.sv */
// reader side: sends a 64-bit code one bit a cycle, or every other cycle
// assumes start is pulsed together with the block's clear
`timescale 1ns/1ps
module code_reader_model (
  input wire logic clock,
  input wire logic start,
  input wire logic slow,
  input wire logic [63:0] code,
  output logic bitValid,
  output logic bitIn
);
  logic [63:0] sh;
  logic [6:0] left = 7'h00;
  logic gap = 1'b0;
  always @(posedge clock) begin
    if (start) begin
      sh <= code;
      left <= 7'h40;
    end else if (bitValid) begin
      sh <= sh >> 1;
      left <= left - 7'h01;
    end
    gap <= !start && bitValid && slow;
  end
  assign bitValid = left != 7'h00 && !gap;
  // between transfers drive the complement of the pending bit
  assign bitIn = bitValid ? sh[0] : ~sh[0];
endmodule : code_reader_model

/* File: test/rom_code_crc8_checker_tb_top.sv */
// bench for the code check block
// assumes package, design, model and checker compile first
`timescale 1ns/1ps
module rom_code_crc8_checker_tb_top;
  logic clock = 0;
  logic rst = 1;
  logic clr = 0;
  logic start = 0;
  logic slow = 0;
  logic bv;
  logic bi;
  logic byv = 0;
  logic [7:0] byd = 8'h00;
  logic [63:0] code = '0;
  logic busy;
  int fails = 0;
  int checkCount = 0;
  int cyc = 0;
  crc8_pkg::crc_in_t req;
  crc8_pkg::crc_out_t status;
  assign req = '{clr, bv, bi, byv, byd};
  code_reader_model code_reader_model_inst (.clock(clock), .start(start), .slow(slow), .code(code),
    .bitValid(bv), .bitIn(bi));
  rom_code_crc8_checker rom_code_crc8_checker_inst (.clock(clock), .rst(rst), .req(req), .status(status),
    .busy(busy));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checkCount++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic sendByte(input logic [7:0] d);
    byv = 1;
    byd = d;
    @(posedge clock) #1 byv = 0;
    chk("busy", 8'h01, {7'h00, busy});
    @(posedge clock) #1;
  endtask : sendByte
  task automatic readCode(input logic [63:0] c, input logic s, input logic g);
    code = c;
    slow = s;
    clr = 1;
    start = 1;
    @(posedge clock) #1 clr = 0;
    start = 0;
    repeat (200) begin
      @(posedge clock) #1;
      if (status.done === 1'b1) break;
    end
    chk("done", 8'h01, {7'h00, status.done});
    chk("count", 8'h40, {1'b0, status.bitCount});
    chk("good", {7'h00, g}, {7'h00, status.good});
    chk("error", {7'h00, !g}, {7'h00, status.error});
    $display("read done");
  endtask : readCode
  task automatic byteRun;
    logic [7:0] b [7] = '{8'h02, 8'h1c, 8'hb8, 8'h01, 8'h00, 8'h00, 8'h00};
    clr = 1;
    @(posedge clock) #1 clr = 0;
    sendByte(8'h02);
    chk("crc", 8'hbc, status.crc);
    sendByte(8'h43);
    chk("crc", 8'h35, status.crc);
    clr = 1;
    @(posedge clock) #1 clr = 0;
    foreach (b[i]) sendByte(b[i]);
    chk("crc", 8'ha2, status.crc);
    sendByte(8'ha2);
    chk("crc", 8'h00, status.crc);
    chk("good", 8'h01, {7'h00, status.good});
    chk("zero", 8'h01, {7'h00, status.isZero});
    $display("bytes done");
  endtask : byteRun
  task automatic testDone;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : testDone
  initial forever #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      testDone();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 0;
    readCode(64'ha2000000_01b81c02, 0, 1);
    readCode(64'ha3000000_01b81c02, 1, 0);
    byteRun();
    testDone();
  end
endmodule : rom_code_crc8_checker_tb_top
bind rom_code_crc8_checker crc8_assertions crc8_assertions_inst (.clock(clock), .rst(rst), .req(req),
  .status(status), .busy(busy));
